// *** timer_pwm_pkg.sv ***
// Purpose: Shared constants and types for the dual timer PWM block.
// Assumes: One system clock; mode codes come from the two per-timer mode bits.
// Notes: Counter widths are fixed at eight bits per byte.
`default_nettype none
package timer_pwm_pkg;
   // Mode codes carried by the two per-timer mode bits.
   typedef enum logic [1:0] {
      MODE_LOG = 2'b00,
      MODE_LIN = 2'b01,
      MODE_SQUARE = 2'b10,
      MODE_SPLIT = 2'b11
   } pwm_mode_t;

   // Result of one counting step of a timer byte pair.
   typedef struct packed {
      logic [7:0] tl;
      logic [7:0] th;
      logic low_wrap;
      logic high_wrap;
      logic th_step;
   } timer_step_t;

   localparam int BYTE_W = 8;
   localparam int TPS_W = 4;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] BYTE_MAX = 8'hff;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [3:0] TPS_RESET = 4'h0;
   localparam logic [8:0] LOG_BASE = 9'h002;
   localparam logic [8:0] LOG_ONE = 9'h001;
endpackage : timer_pwm_pkg
`default_nettype wire

// *** pwm_stage_if.sv ***
// Purpose: Carries one counter's step, count and duty to a compare stage.
// Assumes: Owner and stage share the system clock.
// Notes: The stage returns the active compare value and the output level.
`default_nettype none
interface pwm_stage_if;
   logic step;
   logic wrap;
   logic [7:0] count_next;
   logic [7:0] duty;
   logic [7:0] compare;
   logic level;
   modport stage (input step, input wrap, input count_next, input duty,
      output compare, output level);
   modport owner (output step, output wrap, output count_next, output duty,
      input compare, input level);
endinterface : pwm_stage_if
`default_nettype wire

// *** pwm_compare_stage.sv ***
// Purpose: Buffered duty compare that forms one edge-aligned PWM level.
// Assumes: step marks a count change; wrap marks the FFH to 00H rollover.
// Notes: Duty is sampled only at rollover so mid-period writes cannot glitch.
`default_nettype none
module pwm_compare_stage (
   input wire logic clk,
   input wire logic rst,
   pwm_stage_if.stage port
);
   logic [7:0] compare_reg;
   logic level_reg;

   assign port.compare = compare_reg;
   assign port.level = level_reg;

   // Load the buffered duty at rollover; otherwise hold it.
   always_ff @(posedge clk) begin
      if (rst) begin
         compare_reg <= timer_pwm_pkg::BYTE_RESET;
      end else if (port.step && port.wrap) begin
         compare_reg <= port.duty;
      end
   end

   // Set at rollover unless duty is zero, clear on match.
   always_ff @(posedge clk) begin
      if (rst) begin
         level_reg <= 1'b0;
      end else if (port.step && port.wrap) begin
         level_reg <= (port.duty != timer_pwm_pkg::BYTE_RESET);
      end else if (port.step && port.count_next == compare_reg) begin
         level_reg <= 1'b0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_wrap_load;
      port.step && port.wrap |=> compare_reg == $past(port.duty) &&
         level_reg == ($past(port.duty) != 8'h00);
   endproperty
   a_wrap_load: assert property (p_wrap_load) else $error("Duty not loaded at rollover.");

   property p_match_low;
      port.step && !port.wrap && port.count_next == compare_reg |=> !level_reg;
   endproperty
   a_match_low: assert property (p_match_low) else $error("Output not cleared on match.");

   property p_zero_low;
      compare_reg == 8'h00 |-> !level_reg;
   endproperty
   a_zero_low: assert property (p_zero_low) else $error("Zero duty drove output high.");

   property p_hold_compare;
      !(port.step && port.wrap) |=> compare_reg == $past(compare_reg);
   endproperty
   a_hold_compare: assert property (p_hold_compare) else $error("Compare changed mid-period.");

   c_full_pulse: cover property (port.step && port.wrap && port.duty == 8'h80
      ##[1:300] !level_reg);
endmodule : pwm_compare_stage
`default_nettype wire

// *** timer_pwm_modes.sv ***
// Purpose: PWM operation of timer 0 and timer 1 in four modes.
// Assumes: Control bits arrive as plain ports from the register owner.
// Notes: Pin levels are registered, so they lag the counter by one clock.
//
// Overview of operation
// - Mode 0 low byte divides by two to the select plus one, clocking high counter.
// - Modes 0 and 1 load duty into compare and drive pin high on overflow.
// - Modes 0 and 1 drive pin low when high counter equals compare.
// - Mode 1 low byte reloads from low reload register on each overflow.
// - Timer 1 behaves like timer 0 in modes 0 and 1 with own registers.
// - Mode 2 reloads low byte from high byte and toggles pin each overflow.
// - Mode 2 ignores both reload registers.
// - Timer 1 in mode 3 freezes its count as if stopped.
// - Timer 0 mode 3 runs both bytes as free 8-bit PWM counters.
// - Split mode frequency set only by global prescaler dividing by setting plus one.
// - Split low channel uses timer 0 gate, run, pin, enable and flag.
// - Split high channel counts internal clock with timer 1 run, enable, flag.
// - Split duties come from low reload and high reload registers.
// - Timer 1 stops in its mode 3 while timer 0 splits, giving no baud ticks until it leaves mode 3.
// - Flags keep working in PWM mode; gating can halt the output.
// - Zero duty holds output low; duty changes apply only at rollover.
`default_nettype none
module timer_pwm_modes (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [3:0] GLOBAL_TIMER_PRESCALE,
   input wire logic [1:0] MODE_ZERO,
   input wire logic [1:0] MODE_ONE,
   input wire logic [2:0] LOG_PRESCALE_SELECT_ZERO,
   input wire logic [2:0] LOG_PRESCALE_SELECT_ONE,
   input wire logic RUN_TIMER_ZERO,
   input wire logic RUN_TIMER_ONE,
   input wire logic GATE_ZERO,
   input wire logic GATE_ONE,
   input wire logic EXT_INTERRUPT_ZERO_PIN,
   input wire logic EXT_INTERRUPT_ONE_PIN,
   input wire logic PULSE_MOD_ENABLE_ZERO,
   input wire logic PULSE_MOD_ENABLE_ONE,
   input wire logic [7:0] DUTY_RELOAD_HIGH_ZERO,
   input wire logic [7:0] PRESCALE_RELOAD_LOW_ZERO,
   input wire logic [7:0] DUTY_RELOAD_HIGH_ONE,
   input wire logic [7:0] PRESCALE_RELOAD_LOW_ONE,
   input wire logic CLEAR_OVERFLOW_ZERO,
   input wire logic CLEAR_OVERFLOW_ONE,
   output logic OVERFLOW_FLAG_ZERO,
   output logic OVERFLOW_FLAG_ONE,
   output logic BAUD_TICK_ONE,
   output logic TIMER_ZERO_PIN_OUT,
   output logic TIMER_ZERO_PIN_OE,
   output logic TIMER_ONE_PIN_OUT,
   output logic TIMER_ONE_PIN_OE
);
   // One counting step of a byte pair in the given mode.
   function automatic timer_pwm_pkg::timer_step_t next_step(
      input logic [1:0] mode, input logic [2:0] psc, input logic [7:0] tl,
      input logic [7:0] th, input logic [7:0] rl, input logic [7:0] rh,
      input logic pwm, input logic run_low, input logic run_high);
      timer_pwm_pkg::timer_step_t s;
      logic [8:0] m;
      logic [7:0] mask;
      m = (timer_pwm_pkg::LOG_BASE << psc) - timer_pwm_pkg::LOG_ONE;
      mask = m[7:0];
      s = '{tl: tl, th: th, low_wrap: 1'b0, high_wrap: 1'b0, th_step: 1'b0};
      unique case (timer_pwm_pkg::pwm_mode_t'(mode))
         timer_pwm_pkg::MODE_LOG: if (run_low) begin
            s.low_wrap = ((tl & mask) == mask);
            s.tl = s.low_wrap ? (tl & ~mask) : tl + timer_pwm_pkg::BYTE_ONE;
         end
         timer_pwm_pkg::MODE_LIN: if (run_low) begin
            s.low_wrap = (tl == timer_pwm_pkg::BYTE_MAX);
            s.tl = (s.low_wrap && pwm) ? rl : tl + timer_pwm_pkg::BYTE_ONE;
         end
         timer_pwm_pkg::MODE_SQUARE: if (run_low) begin
            s.low_wrap = (tl == timer_pwm_pkg::BYTE_MAX);
            s.tl = s.low_wrap ? th : tl + timer_pwm_pkg::BYTE_ONE;
         end
         timer_pwm_pkg::MODE_SPLIT: begin
            if (run_low) begin
               s.low_wrap = (tl == timer_pwm_pkg::BYTE_MAX);
               s.tl = tl + timer_pwm_pkg::BYTE_ONE;
            end
            if (run_high) begin
               s.th_step = 1'b1;
               s.high_wrap = (th == timer_pwm_pkg::BYTE_MAX);
               s.th = th + timer_pwm_pkg::BYTE_ONE;
            end
         end
      endcase
      if (mode != 2'b10 && mode != 2'b11 && s.low_wrap) begin
         s.th_step = 1'b1;
         s.high_wrap = (th == timer_pwm_pkg::BYTE_MAX);
         s.th = th + timer_pwm_pkg::BYTE_ONE;
         if (!pwm && mode == 2'b01 && s.high_wrap) begin
            s.th = rh;
            s.tl = rl;
         end
      end
      return s;
   endfunction : next_step

   logic ext_interrupt_zero_pin_meta_reg, ext_interrupt_zero_pin_sync_reg, int1_meta_reg, int1_sync_reg;
   logic [3:0] pre_cnt_reg;
   logic tick;
   logic split, run0, run1, run_th0;
   logic [7:0] tl0_reg, th0_reg, tl1_reg, th1_reg;
   timer_pwm_pkg::timer_step_t s0, s1;
   logic tf0_reg, tf1_reg, baud_reg;
   logic toggle0_reg, toggle1_reg;
   logic pin0_reg, pin1_reg;
   logic set0, set1;

   // External gate pins pass two flip-flops before any use.
   always_ff @(posedge CLK) begin
      if (RST) begin
         ext_interrupt_zero_pin_meta_reg <= 1'b0;
         ext_interrupt_zero_pin_sync_reg <= 1'b0;
         int1_meta_reg <= 1'b0;
         int1_sync_reg <= 1'b0;
      end else begin
         ext_interrupt_zero_pin_meta_reg <= EXT_INTERRUPT_ZERO_PIN;
         ext_interrupt_zero_pin_sync_reg <= ext_interrupt_zero_pin_meta_reg;
         int1_meta_reg <= EXT_INTERRUPT_ONE_PIN;
         int1_sync_reg <= int1_meta_reg;
      end
   end

   // Global prescaler gives one tick every setting plus one clocks.
   always_ff @(posedge CLK) begin
      if (RST || tick) begin
         pre_cnt_reg <= timer_pwm_pkg::TPS_RESET;
      end else begin
         pre_cnt_reg <= pre_cnt_reg + 4'h1;
      end
   end
   assign tick = (pre_cnt_reg >= GLOBAL_TIMER_PRESCALE);

   // Run conditions, gate applied from the synchronised pins.
   assign split = (MODE_ZERO == 2'b11);
   assign run0 = tick && RUN_TIMER_ZERO && (!GATE_ZERO || ext_interrupt_zero_pin_sync_reg);
   assign run1 = tick && RUN_TIMER_ONE && (!GATE_ONE || int1_sync_reg) &&
      (MODE_ONE != 2'b11);
   assign run_th0 = tick && RUN_TIMER_ONE;
   assign s0 = next_step(MODE_ZERO, LOG_PRESCALE_SELECT_ZERO, tl0_reg, th0_reg,
      PRESCALE_RELOAD_LOW_ZERO, DUTY_RELOAD_HIGH_ZERO, PULSE_MOD_ENABLE_ZERO, run0, run_th0);
   assign s1 = next_step(MODE_ONE, LOG_PRESCALE_SELECT_ONE, tl1_reg, th1_reg,
      PRESCALE_RELOAD_LOW_ONE, DUTY_RELOAD_HIGH_ONE, PULSE_MOD_ENABLE_ONE, run1, 1'b0);

   // Counter bytes of both timers.
   always_ff @(posedge CLK) begin
      if (RST) begin
         tl0_reg <= timer_pwm_pkg::BYTE_RESET;
         th0_reg <= timer_pwm_pkg::BYTE_RESET;
         tl1_reg <= timer_pwm_pkg::BYTE_RESET;
         th1_reg <= timer_pwm_pkg::BYTE_RESET;
      end else begin
         tl0_reg <= s0.tl;
         th0_reg <= s0.th;
         tl1_reg <= s1.tl;
         th1_reg <= s1.th;
      end
   end

   // Overflow flags; a set in the clearing cycle wins.
   assign set0 = (MODE_ZERO[1]) ? s0.low_wrap : s0.high_wrap;
   assign set1 = split ? s0.high_wrap : (MODE_ONE == 2'b10 ? s1.low_wrap : s1.high_wrap);
   always_ff @(posedge CLK) begin
      if (RST) begin
         tf0_reg <= 1'b0;
         tf1_reg <= 1'b0;
      end else begin
         tf0_reg <= set0 || (tf0_reg && !CLEAR_OVERFLOW_ZERO);
         tf1_reg <= set1 || (tf1_reg && !CLEAR_OVERFLOW_ONE);
      end
   end

   // Timer 1 overflow pulse for the serial port, also in split mode.
   always_ff @(posedge CLK) begin
      if (RST) begin
         baud_reg <= 1'b0;
      end else begin
         baud_reg <= (MODE_ONE == 2'b10) ? s1.low_wrap : s1.high_wrap;
      end
   end

   // Square wave toggles on each low byte overflow.
   always_ff @(posedge CLK) begin
      if (RST) begin
         toggle0_reg <= 1'b0;
         toggle1_reg <= 1'b0;
      end else begin
         if (MODE_ZERO == 2'b10 && s0.low_wrap) begin
            toggle0_reg <= !toggle0_reg;
         end
         if (MODE_ONE == 2'b10 && s1.low_wrap) begin
            toggle1_reg <= !toggle1_reg;
         end
      end
   end

   pwm_stage_if hi0_if ();
   pwm_stage_if lo0_if ();
   pwm_stage_if hi1_if ();

   // Compare stages: timer 0 high, timer 0 split low, timer 1 high.
   assign hi0_if.step = s0.th_step;
   assign hi0_if.wrap = s0.high_wrap;
   assign hi0_if.count_next = s0.th;
   assign hi0_if.duty = DUTY_RELOAD_HIGH_ZERO;
   assign lo0_if.step = split && run0;
   assign lo0_if.wrap = s0.low_wrap;
   assign lo0_if.count_next = s0.tl;
   assign lo0_if.duty = PRESCALE_RELOAD_LOW_ZERO;
   assign hi1_if.step = s1.th_step;
   assign hi1_if.wrap = s1.high_wrap;
   assign hi1_if.count_next = s1.th;
   assign hi1_if.duty = DUTY_RELOAD_HIGH_ONE;

   pwm_compare_stage u_hi0 (.clk(CLK), .rst(RST), .port(hi0_if.stage));
   pwm_compare_stage u_lo0 (.clk(CLK), .rst(RST), .port(lo0_if.stage));
   pwm_compare_stage u_hi1 (.clk(CLK), .rst(RST), .port(hi1_if.stage));

   // Registered pin levels selected by mode and enable.
   always_ff @(posedge CLK) begin
      if (RST) begin
         pin0_reg <= 1'b0;
         pin1_reg <= 1'b0;
      end else begin
         pin0_reg <= PULSE_MOD_ENABLE_ZERO && (MODE_ZERO == 2'b10 ? toggle0_reg :
            (split ? lo0_if.level : hi0_if.level));
         pin1_reg <= PULSE_MOD_ENABLE_ONE && (split ? hi0_if.level :
            (MODE_ONE == 2'b10 ? toggle1_reg : hi1_if.level));
      end
   end

   assign OVERFLOW_FLAG_ZERO = tf0_reg;
   assign OVERFLOW_FLAG_ONE = tf1_reg;
   assign BAUD_TICK_ONE = baud_reg;
   assign TIMER_ZERO_PIN_OUT = pin0_reg;
   assign TIMER_ONE_PIN_OUT = pin1_reg;
   assign TIMER_ZERO_PIN_OE = PULSE_MOD_ENABLE_ZERO;
   assign TIMER_ONE_PIN_OE = PULSE_MOD_ENABLE_ONE;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   property p_log_carry;
      run0 && MODE_ZERO == 2'b00 && LOG_PRESCALE_SELECT_ZERO == 3'h0 && tl0_reg[0]
         |=> th0_reg == $past(th0_reg) + 8'h01;
   endproperty
   a_log_carry: assert property (p_log_carry) else $error("Log prescaler carry missed.");

   property p_lin_reload;
      run0 && MODE_ZERO == 2'b01 && PULSE_MOD_ENABLE_ZERO && tl0_reg == 8'hff
         |=> tl0_reg == $past(PRESCALE_RELOAD_LOW_ZERO);
   endproperty
   a_lin_reload: assert property (p_lin_reload) else $error("Linear reload wrong.");

   property p_square_toggle;
      run0 && MODE_ZERO == 2'b10 && tl0_reg == 8'hff
         |=> toggle0_reg != $past(toggle0_reg) && tl0_reg == $past(th0_reg);
   endproperty
   a_square_toggle: assert property (p_square_toggle) else $error("Square toggle missed.");

   property p_one_frozen;
      MODE_ONE == 2'b11 |=> tl1_reg == $past(tl1_reg) && th1_reg == $past(th1_reg);
   endproperty
   a_one_frozen: assert property (p_one_frozen) else $error("Timer 1 moved in mode 3.");

   property p_split_high;
      split && tick && RUN_TIMER_ONE |=> th0_reg == $past(th0_reg) + 8'h01;
   endproperty
   a_split_high: assert property (p_split_high) else $error("Split high byte stalled.");

   property p_tick_gap;
      tick && GLOBAL_TIMER_PRESCALE == 4'h1 ##1 $stable(GLOBAL_TIMER_PRESCALE)
         |-> !tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("Prescale tick too early.");

   property p_gate_halt;
      GATE_ZERO && !ext_interrupt_zero_pin_sync_reg |=> tl0_reg == $past(tl0_reg);
   endproperty
   a_gate_halt: assert property (p_gate_halt) else $error("Gate did not halt timer 0.");

   property p_flag_set_wins;
      set1 && CLEAR_OVERFLOW_ONE |=> tf1_reg;
   endproperty
   a_flag_set_wins: assert property (p_flag_set_wins) else $error("Overflow flag lost.");

   c_split_both: cover property (split && lo0_if.level && hi0_if.level);
   c_square: cover property (MODE_ZERO == 2'b10 && PULSE_MOD_ENABLE_ZERO ##1 $rose(pin0_reg));
   c_timer1_pwm: cover property (MODE_ONE == 2'b01 && $fell(pin1_reg));
endmodule : timer_pwm_modes
`default_nettype wire

// *** pwm_load_model.sv ***
// Purpose: Load on one PWM pin that measures period and high time.
// Assumes: The pin is pulled low whenever its driver is off.
// Notes: Both figures update at each rising edge of the seen level.
`default_nettype none
module pwm_load_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   input wire logic oe,
   output logic [15:0] high_len,
   output logic [15:0] period_len,
   output logic [15:0] rises
);
   timeunit 1ns;
   timeprecision 1ns;
   logic level;
   logic level_reg;
   logic [15:0] cnt_reg;
   logic [15:0] hi_reg;
   // The load only sees the waveform while the pin is an output.
   assign level = oe ? pin : 1'b0;
   // Count cycles and high cycles, and latch both at each rising edge.
   always_ff @(posedge clk) begin
      level_reg <= level;
      if (rst) begin
         cnt_reg <= 16'h0000;
         hi_reg <= 16'h0000;
         rises <= 16'h0000;
         high_len <= 16'h0000;
         period_len <= 16'h0000;
      end else if (level && !level_reg) begin
         period_len <= cnt_reg;
         high_len <= hi_reg;
         rises <= rises + 16'h0001;
         cnt_reg <= 16'h0001;
         hi_reg <= 16'h0001;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
         hi_reg <= hi_reg + {15'h0000, level};
      end
   end
endmodule : pwm_load_model
`default_nettype wire

// *** timer_pwm_modes_tb_top.sv ***
// Purpose: Self-checking bench for the dual timer PWM block.
// Assumes: Two pin loads measure each waveform; timer 1 gate is unused.
// Notes: Every measurement but the buffered-duty check skips one partial period after a change.
`default_nettype none
module timer_pwm_modes_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] global_timer_prescale = 4'h0;
   logic [1:0] m0 = timer_pwm_pkg::MODE_SQUARE;
   logic [1:0] m1 = timer_pwm_pkg::MODE_LIN;
   logic [2:0] ps0 = 3'h0;
   logic [2:0] ps1 = 3'h0;
   logic run0 = 1'b1;
   logic run1 = 1'b1;
   logic gate0 = 1'b0;
   logic ext0 = 1'b0;
   logic en0 = 1'b1;
   logic en1 = 1'b1;
   logic clr0 = 1'b0;
   logic clr1 = 1'b0;
   logic [7:0] rh0 = 8'h00;
   logic [7:0] rl0 = 8'h00;
   logic [7:0] rh1 = 8'h00;
   logic [7:0] rl1 = 8'h00;
   logic of0, of1, baud, p0, oe0, p1, oe1;
   logic [15:0] hl0, pl0, rs0, hl1, pl1, rs1;
   int n_fail = 0;
   int n_tests = 0;
   int nb = 0;
   int b;
   bit g;

   timer_pwm_modes timer_pwm_modes_i (.CLK(clk), .RST(rst), .GLOBAL_TIMER_PRESCALE(global_timer_prescale),
      .MODE_ZERO(m0), .MODE_ONE(m1), .LOG_PRESCALE_SELECT_ZERO(ps0),
      .LOG_PRESCALE_SELECT_ONE(ps1), .RUN_TIMER_ZERO(run0), .RUN_TIMER_ONE(run1),
      .GATE_ZERO(gate0), .GATE_ONE(1'b0), .EXT_INTERRUPT_ZERO_PIN(ext0),
      .EXT_INTERRUPT_ONE_PIN(1'b0), .PULSE_MOD_ENABLE_ZERO(en0), .PULSE_MOD_ENABLE_ONE(en1),
      .DUTY_RELOAD_HIGH_ZERO(rh0), .PRESCALE_RELOAD_LOW_ZERO(rl0),
      .DUTY_RELOAD_HIGH_ONE(rh1), .PRESCALE_RELOAD_LOW_ONE(rl1),
      .CLEAR_OVERFLOW_ZERO(clr0), .CLEAR_OVERFLOW_ONE(clr1), .OVERFLOW_FLAG_ZERO(of0),
      .OVERFLOW_FLAG_ONE(of1), .BAUD_TICK_ONE(baud), .TIMER_ZERO_PIN_OUT(p0),
      .TIMER_ZERO_PIN_OE(oe0), .TIMER_ONE_PIN_OUT(p1), .TIMER_ONE_PIN_OE(oe1));
   pwm_load_model pwm_load_model_i (.clk(clk), .rst(rst), .pin(p0), .oe(oe0),
      .high_len(hl0), .period_len(pl0), .rises(rs0));
   pwm_load_model pwm_load_model_i1 (.clk(clk), .rst(rst), .pin(p1), .oe(oe1),
      .high_len(hl1), .period_len(pl1), .rises(rs1));

   // Free-running system clock at 125 MHz.
   always #4 clk = ~clk;

   // Count baud ticks so frozen and running timer 1 can be told apart.
   always @(posedge clk) begin
      if (baud === 1'b1) nb <= nb + 1;
   end

   // Compare one value and count the outcome.
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk

   // Wait up to lim cycles for a rising edge on one pin.
   task automatic wait_rise(input int ch, input int lim, output bit got);
      logic [15:0] r0;
      int k;
      r0 = ch ? rs1 : rs0;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while ((ch ? rs1 : rs0) === r0 && k < lim);
      got = ((ch ? rs1 : rs0) !== r0);
   endtask : wait_rise

   // Skip a partial period, then check one whole period and its high time.
   task automatic meas(input int ch, input int lim, input logic [15:0] per,
      input logic [15:0] hi);
      bit got;
      wait_rise(ch, lim, got);
      wait_rise(ch, lim, got);
      chk("rise seen", {31'h0, got}, 32'h1);
      chk("period", {16'h0, ch ? pl1 : pl0}, {16'h0, per});
      chk("high time", {16'h0, ch ? hl1 : hl0}, {16'h0, hi});
   endtask : meas

   // Check that a pin shows no rising edge for n cycles.
   task automatic quiet(input int ch, input int n);
      bit got;
      wait_rise(ch, n, got);
      chk("no rise", {31'h0, got}, 32'h0);
   endtask : quiet

   // Print the counts and the verdict, then end the run.
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done

   // Cut a hang short well beyond the expected run of about 50000 cycles.
   initial begin
      repeat (90000) @(posedge clk);
      n_fail++;
      test_done();
   end

   // Main sequence of scenarios.
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      // Square wave with th at zero: toggle every 256 ticks.
      meas(0, 700, 16'd512, 16'd256);
      @(posedge clk);
      rh0 <= 8'h5a;
      rl0 <= 8'hc3;
      meas(0, 700, 16'd512, 16'd256);
      // Linear prescaler on both timers with distinct reloads and duties.
      @(posedge clk);
      m0 <= timer_pwm_pkg::MODE_LIN;
      rl0 <= 8'hf0;
      rh0 <= 8'h40;
      rl1 <= 8'hf8;
      rh1 <= 8'h80;
      meas(0, 4600, 16'd4096, 16'd1024);
      meas(1, 2200, 16'd2048, 16'd1024);
      // A duty written mid-period only lands at the next rollover; zero holds low.
      wait_rise(0, 4200, g);
      @(posedge clk);
      rh0 <= 8'h20;
      wait_rise(0, 4200, g);
      chk("buffered duty", {16'h0, hl0}, 32'd1024);
      chk("buffered period", {16'h0, pl0}, 32'd4096);
      @(posedge clk);
      rh0 <= 8'h00;
      quiet(0, 8300);
      // Logarithmic prescaler, including the full-scale duty.
      @(posedge clk);
      m0 <= timer_pwm_pkg::MODE_LOG;
      m1 <= timer_pwm_pkg::MODE_LOG;
      ps1 <= 3'h2;
      rh0 <= 8'h20;
      rh1 <= 8'hff;
      meas(0, 1100, 16'd512, 16'd64);
      meas(1, 4200, 16'd2048, 16'd2040);
      // Overflow flag sets at rollover and clears on request.
      wait_rise(0, 1100, g);
      chk("flag set", {31'h0, of0}, 32'h1);
      @(posedge clk);
      clr0 <= 1'b1;
      @(posedge clk);
      clr0 <= 1'b0;
      @(negedge clk);
      chk("flag cleared", {31'h0, of0}, 32'h0);
      wait_rise(0, 1100, g);
      chk("flag again", {31'h0, of0}, 32'h1);
      // Gating by the external pin halts and restarts the output.
      @(posedge clk);
      gate0 <= 1'b1;
      quiet(0, 1200);
      @(posedge clk);
      ext0 <= 1'b1;
      meas(0, 1100, 16'd512, 16'd64);
      // Timer 1 in mode 3 holds its count.
      @(posedge clk);
      m1 <= timer_pwm_pkg::MODE_SPLIT;
      quiet(1, 4300);
      // Split timer 0: two channels, frequency from the global prescaler.
      @(posedge clk);
      m0 <= timer_pwm_pkg::MODE_SPLIT;
      global_timer_prescale <= 4'h1;
      rl0 <= 8'h40;
      rh0 <= 8'h10;
      meas(0, 1100, 16'd512, 16'd128);
      meas(1, 1100, 16'd512, 16'd32);
      // Frozen timer 1 gives no baud ticks while clear 1 is held; mode 2 resumes them, then flag 1 is checked.
      b = nb;
      @(posedge clk);
      clr1 <= 1'b1;
      repeat (1100) @(posedge clk);
      chk("baud frozen", nb - b, 32'h0);
      @(posedge clk);
      clr1 <= 1'b0;
      m1 <= timer_pwm_pkg::MODE_SQUARE;
      repeat (1100) @(posedge clk);
      chk("baud resumed", {31'h0, nb > b}, 32'h1);
      wait_rise(1, 1100, g);
      chk("flag one", {31'h0, of1}, 32'h1);
      @(posedge clk);
      run1 <= 1'b0;
      quiet(1, 1200);
      // Dropping the enable releases the pin.
      @(posedge clk);
      en0 <= 1'b0;
      @(negedge clk);
      chk("pin enable", {30'h0, oe0, oe1}, 32'h1);
      test_done();
   end
endmodule : timer_pwm_modes_tb_top
`default_nettype wire
